// *** inc/spio_pkg.sv ***
package spio_pkg;

  // Port geometry
  localparam int unsigned PORT_W = 8;

  // Register byte offsets within the slave window
  localparam int unsigned DEC_W       = 12;
  localparam logic [11:0] ADDR_DIR    = 12'h000;
  localparam logic [11:0] ADDR_DATA   = 12'h004;

  // Reset values
  localparam logic [7:0] DIR_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // Pin positions of the shared functions
  localparam int unsigned PIN_SER_TX  = 0;
  localparam int unsigned PIN_SER_RX  = 1;
  localparam int unsigned PIN_SER_CLK = 2;
  localparam int unsigned PIN_T1_CLK  = 3;
  localparam int unsigned PIN_T1_CMP  = 4;
  localparam int unsigned PIN_T1_RST  = 5;
  localparam int unsigned PIN_PWM0    = 6;
  localparam int unsigned PIN_PWM1    = 7;

  // Field codes of the neighbouring peripherals
  localparam logic [1:0] CLEAR_BY_PIN = 2'b11;
  localparam logic [3:0] CMP_OUT_OFF  = 4'h0;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Control bits taken from the pwm, timer and serial units
  typedef struct packed {
    logic       pwm_chan_b_out_en;
    logic       pwm_chan_a_out_en;
    logic [1:0] timer1_clear_sel;
    logic [1:0] timer0_clear_sel;
    logic [3:0] timer1_compare_output_select;
    logic [3:0] timer0_compare_output_select;
    logic       timer1_ext_clk_sel;
    logic       timer0_ext_clk_sel;
    logic       serial_clk_enable_hi;
    logic       serial_clk_enable_lo;
    logic       serial_sync_mode;
    logic       receive_enable;
    logic       transmit_enable;
  } spio_ctl_t;

  // Levels that peripherals want driven onto pins
  typedef struct packed {
    logic pwm_out_1;
    logic pwm_out_0;
    logic timer1_compare_out;
    logic timer0_compare_out;
    logic serial_clock_out;
    logic serial_transmit;
  } spio_drv_t;

  // Pin levels handed to peripherals
  typedef struct packed {
    logic timer1_reset_in;
    logic timer1_ext_clock_in;
    logic timer0_reset_in;
    logic timer0_ext_clock_in;
    logic serial_clock_in;
    logic serial_receive;
  } spio_feed_t;

  // Whole state of the port
  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  data;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    spio_feed_t  feed;
    logic        dph_wr;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
  } spio_state_t;

endpackage

// *** src/spio_port.sv ***
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// How it works
// - Eight pins, each with its own direction bit and output data bit.
// - Direction bit 1 makes an output, 0 an input; write-only, resets to 0.
// - Reading the port returns stored data for pins whose direction is 1.
// - Reading the port returns the sampled pin level for pins whose direction is 0.
// - In software standby pwm and serial are off; timers and port registers rule.
// - Pin 7 drives pwm output 1 while channel B output enable is 1.
// - Pin 6 drives pwm output 0 while channel A output enable is 1.
// - Pin 5 is plain I/O, and feeds timer 1 reset when clear select is 11.
// - Pin 4 drives timer 1 compare output when its output select is nonzero.
// - Pin 3 is plain I/O, and supplies timer 1 external clock when selected.
// - Pin 2 is serial clock input, clock output, or plain I/O by clock enables and sync mode.
// - Pin 2 also feeds timer 0 reset when its clear select is 11.
// - Pin 1: timer 0 compare out, else serial receive input, else plain I/O.
// - Pin 0 drives serial transmit while transmit enable is 1.
// - Pin 0 also supplies timer 0 external clock when that clock is selected.
// - Multiplexing and register behaviour are the same in every chip mode.
// - Output data register is read/write and resets to all zeros.
module spio_port (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                standby,
  input  wire spio_pkg::spio_ctl_t ctl,
  input  wire spio_pkg::spio_drv_t drv,
  input  wire logic [7:0]          pin_in,
  output logic [7:0]               pin_out,
  output logic [7:0]               pin_oe,
  output spio_pkg::spio_feed_t     feed
);

  spio_pkg::spio_state_t s_q;
  spio_pkg::spio_state_t s_d;

  // Effective peripheral enables after the standby override
  logic       pwm_b_on;
  logic       pwm_a_on;
  logic       tx_on;
  logic       rx_on;
  logic       clk_in_on;
  logic       clk_out_on;
  logic       t1_cmp_on;
  logic       t0_cmp_on;
  logic       addr_take;
  logic [7:0] wdata_byte;
  logic [7:0] port_view;

  // Standby resets pwm and serial, so their claims on pins drop out
  always_comb begin
    pwm_b_on   = ctl.pwm_chan_b_out_en & ~standby;
    pwm_a_on   = ctl.pwm_chan_a_out_en & ~standby;
    tx_on      = ctl.transmit_enable & ~standby;
    rx_on      = ctl.receive_enable & ~standby;
    clk_in_on  = ctl.serial_clk_enable_hi & ~standby;
    clk_out_on = ~ctl.serial_clk_enable_hi & ~standby
                 & (ctl.serial_sync_mode | ctl.serial_clk_enable_lo);
    // Timers keep running in standby and still own their pins
    t1_cmp_on  = ctl.timer1_compare_output_select != spio_pkg::CMP_OUT_OFF;
    t0_cmp_on  = ctl.timer0_compare_output_select != spio_pkg::CMP_OUT_OFF;
  end

  // Bus address phase taken only when the previous transfer has completed
  assign addr_take  = hsel & hready & (htrans == spio_pkg::HTRANS_NONSEQ);
  assign wdata_byte = hwdata[7:0];

  always_comb begin
    s_d = s_q;

    // Two-stage synchroniser; only the second stage is looked at
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;

    // Data-phase writes; no mode input exists, so decode never varies
    if (s_q.dph_wr) begin
      if (s_q.dph_addr == spio_pkg::ADDR_DIR) begin
        s_d.dir = wdata_byte;
      end else if (s_q.dph_addr == spio_pkg::ADDR_DATA) begin
        s_d.data = wdata_byte;
      end
    end

    // Per-bit read mux uses the just-written registers for back-to-back access
    port_view = (s_d.data & s_d.dir)
                | (s_q.sync2 & ~s_d.dir);

    // Address phase; reads prepared now so the data phase has no wait state
    s_d.dph_wr = 1'b0;
    if (addr_take) begin
      s_d.dph_wr   = hwrite;
      s_d.dph_addr = haddr[11:0];
      s_d.rdata    = 32'h0000_0000;
      if (!hwrite && haddr[11:0] == spio_pkg::ADDR_DATA) begin
        s_d.rdata = {24'h00_0000, port_view};
      end
      // Direction is write-only and unmapped offsets read zero
    end

    // Default general-purpose behaviour on every pin
    s_d.pin_oe  = s_d.dir;
    s_d.pin_out = s_d.data;

    // Pin 7: pwm output 1 overrides, registers left intact
    if (pwm_b_on) begin
      s_d.pin_oe[spio_pkg::PIN_PWM1]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_PWM1] = drv.pwm_out_1;
    end

    // Pin 6: pwm output 0
    if (pwm_a_on) begin
      s_d.pin_oe[spio_pkg::PIN_PWM0]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_PWM0] = drv.pwm_out_0;
    end

    // Pin 4: timer 1 compare output
    if (t1_cmp_on) begin
      s_d.pin_oe[spio_pkg::PIN_T1_CMP]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_T1_CMP] = drv.timer1_compare_out;
    end

    // Pin 2: serial clock; input wins over output
    if (clk_in_on) begin
      s_d.pin_oe[spio_pkg::PIN_SER_CLK]  = 1'b0;
      s_d.pin_out[spio_pkg::PIN_SER_CLK] = 1'b0;
    end else if (clk_out_on) begin
      s_d.pin_oe[spio_pkg::PIN_SER_CLK]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_SER_CLK] = drv.serial_clock_out;
    end

    // Pin 1: compare output ahead of receive; software keeps them apart
    if (t0_cmp_on) begin
      s_d.pin_oe[spio_pkg::PIN_SER_RX]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_SER_RX] = drv.timer0_compare_out;
    end else if (rx_on) begin
      s_d.pin_oe[spio_pkg::PIN_SER_RX]  = 1'b0;
      s_d.pin_out[spio_pkg::PIN_SER_RX] = 1'b0;
    end

    // Pin 0: serial or infrared transmit
    if (tx_on) begin
      s_d.pin_oe[spio_pkg::PIN_SER_TX]  = 1'b1;
      s_d.pin_out[spio_pkg::PIN_SER_TX] = drv.serial_transmit;
    end

    // Feeds to peripherals come from synchronised levels and stay low when unused
    s_d.feed.timer1_reset_in     = (ctl.timer1_clear_sel == spio_pkg::CLEAR_BY_PIN)
                                   & s_q.sync2[spio_pkg::PIN_T1_RST];
    s_d.feed.timer1_ext_clock_in = ctl.timer1_ext_clk_sel
                                   & s_q.sync2[spio_pkg::PIN_T1_CLK];
    s_d.feed.timer0_reset_in     = (ctl.timer0_clear_sel == spio_pkg::CLEAR_BY_PIN)
                                   & s_q.sync2[spio_pkg::PIN_SER_CLK];
    s_d.feed.timer0_ext_clock_in = ctl.timer0_ext_clk_sel
                                   & s_q.sync2[spio_pkg::PIN_SER_TX];
    s_d.feed.serial_clock_in     = clk_in_on & s_q.sync2[spio_pkg::PIN_SER_CLK];
    // Receive path is cut while the compare output owns the pin
    s_d.feed.serial_receive      = rx_on & ~t0_cmp_on
                                   & s_q.sync2[spio_pkg::PIN_SER_RX];
  end

  // Single state register; async reset loads constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.dir      <= spio_pkg::DIR_RESET;
      s_q.data     <= spio_pkg::DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave: always ready, always OKAY, so these are constant flops
  logic ready_q;
  logic resp_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q  <= spio_pkg::HRESP_OKAY;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= spio_pkg::HRESP_OKAY;
    end
  end

  // Outputs straight from flops
  assign hreadyout = ready_q;
  assign hresp     = resp_q;
  assign hrdata    = s_q.rdata;
  assign pin_out   = s_q.pin_out;
  assign pin_oe    = s_q.pin_oe;
  assign feed      = s_q.feed;

  // Transfer size is not checked; only byte lane 0 carries register bits
  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:8], haddr[31:12]};

endmodule

// *** verif/spio_board.sv ***
`timescale 1ns/1ps
module spio_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] board,
  output logic [7:0]      pin_in
);
  // Driven pins read back their own level, released pins the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

// *** verif/spio_port_monitor.sv ***
`timescale 1ns/1ps
module spio_mon (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 standby,
  input wire spio_pkg::spio_ctl_t  ctl,
  input wire spio_pkg::spio_drv_t  drv,
  input wire logic [7:0]           pin_in,
  input wire logic [7:0]           pin_out,
  input wire logic [7:0]           pin_oe,
  input wire spio_pkg::spio_feed_t feed
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Peripheral drives land one edge after the control
  a_pwm1_drive: assert property (
    (ctl.pwm_chan_b_out_en && !standby) |=> pin_oe[7] && pin_out[7] == $past(drv.pwm_out_1))
    else $error("pin 7 not carrying pwm output 1");
  a_pwm0_drive: assert property (
    (ctl.pwm_chan_a_out_en && !standby) |=> pin_oe[6] && pin_out[6] == $past(drv.pwm_out_0))
    else $error("pin 6 not carrying pwm output 0");
  a_t1_compare: assert property (
    (ctl.timer1_compare_output_select != spio_pkg::CMP_OUT_OFF)
    |=> pin_oe[4] && pin_out[4] == $past(drv.timer1_compare_out))
    else $error("pin 4 not carrying timer 1 compare");
  a_t0_compare: assert property (
    (ctl.timer0_compare_output_select != spio_pkg::CMP_OUT_OFF)
    |=> pin_oe[1] && pin_out[1] == $past(drv.timer0_compare_out))
    else $error("pin 1 not carrying timer 0 compare");
  a_tx_drive: assert property (
    (ctl.transmit_enable && !standby) |=> pin_oe[0] && pin_out[0] == $past(drv.serial_transmit))
    else $error("pin 0 not carrying serial transmit");
  a_clk_input: assert property (
    (ctl.serial_clk_enable_hi && !standby) |=> !pin_oe[2])
    else $error("pin 2 driven while a clock input");
  a_clk_output: assert property (
    (!ctl.serial_clk_enable_hi && (ctl.serial_sync_mode || ctl.serial_clk_enable_lo) && !standby)
    |=> pin_oe[2] && pin_out[2] == $past(drv.serial_clock_out))
    else $error("pin 2 not carrying serial clock out");
  // Two sync flops plus the feed register
  a_t1_reset_feed: assert property (
    (ctl.timer1_clear_sel == spio_pkg::CLEAR_BY_PIN && pin_in[5]) [*4] |=> feed.timer1_reset_in)
    else $error("timer 1 reset feed not following pin 5");
endmodule

bind spio_port spio_mon u_mon (
  .hclk    (hclk),
  .hresetn (hresetn),
  .standby (standby),
  .ctl     (ctl),
  .drv     (drv),
  .pin_in  (pin_in),
  .pin_out (pin_out),
  .pin_oe  (pin_oe),
  .feed    (feed)
);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, standby, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] board, pin_in, pin_out, pin_oe;
  spio_pkg::spio_ctl_t ctl;
  spio_pkg::spio_drv_t drv;
  spio_pkg::spio_feed_t feed;
  int n_errors, n_compared;
  // Pins that each shared function takes over
  localparam logic [7:0] MUX_PIN [6] = '{8'h80, 8'h40, 8'h10, 8'h02, 8'h01, 8'h04};

  spio_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .standby(standby), .ctl(ctl), .drv(drv), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .feed(feed));
  spio_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .pin_in(pin_in));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single AHB transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= spio_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {20'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Reset levels on the pins, then the stored data seen through an output direction
  task automatic t_reset();
    chk({16'h0000, pin_oe, pin_out}, 32'h0000_0000);
    chk({31'h0, hresp}, {31'h0, spio_pkg::HRESP_OKAY});
    bus(1'b0, spio_pkg::ADDR_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b0, spio_pkg::ADDR_DIR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, spio_pkg::ADDR_DIR, 32'h0000_00ff);
    bus(1'b0, spio_pkg::ADDR_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, spio_pkg::ADDR_DIR, 32'h0000_0000);
  endtask

  // Mixed directions, then a peripheral fighting a stored output bit
  task automatic t_gpio();
    board <= 8'h3c;
    bus(1'b1, spio_pkg::ADDR_DIR, 32'h0000_00f0);
    bus(1'b1, spio_pkg::ADDR_DATA, 32'h0000_00a5);
    cyc(3);
    chk({16'h0000, pin_oe, pin_out & pin_oe}, 32'h0000_f0a0);
    bus(1'b0, spio_pkg::ADDR_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_00ac);
    ctl.pwm_chan_b_out_en <= 1'b1;
    cyc(3);
    chk({31'h0, pin_out[7]}, 32'h0000_0000);
    bus(1'b0, spio_pkg::ADDR_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_00ac);
    ctl <= '0;
  endtask

  // Every output function, awake and in standby
  task automatic t_mux();
    spio_pkg::spio_ctl_t c;
    logic [7:0] m;
    bus(1'b1, spio_pkg::ADDR_DIR, 32'h0000_0000);
    bus(1'b1, spio_pkg::ADDR_DATA, 32'h0000_0000);
    drv <= '1;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        c = '0;
        case (i)
          0: c.pwm_chan_b_out_en = 1'b1;
          1: c.pwm_chan_a_out_en = 1'b1;
          2: c.timer1_compare_output_select = 4'h8;
          3: c.timer0_compare_output_select = 4'h1;
          4: c.transmit_enable = 1'b1;
          default: c.serial_sync_mode = 1'b1;
        endcase
        m = (s == 1 && i != 2 && i != 3) ? 8'h00 : MUX_PIN[i];
        ctl <= c;
        standby <= s[0];
        cyc(3);
        chk({24'h00_0000, pin_oe}, {24'h00_0000, m});
        chk({24'h00_0000, pin_out}, {24'h00_0000, m});
      end
    end
    ctl <= '0;
    standby <= 1'b0;
    cyc(3);
    chk({24'h00_0000, pin_oe}, 32'h0000_0000);
  endtask

  // Pin levels handed to timers and serial unit, then gated off
  task automatic t_feed();
    spio_pkg::spio_ctl_t c;
    // Whole control word built first so ctl is assigned once per step
    c = '0;
    c.timer1_clear_sel = spio_pkg::CLEAR_BY_PIN;
    c.timer0_clear_sel = spio_pkg::CLEAR_BY_PIN;
    c.timer1_ext_clk_sel = 1'b1;
    c.timer0_ext_clk_sel = 1'b1;
    c.receive_enable = 1'b1;
    c.serial_clk_enable_hi = 1'b1;
    ctl <= c;
    board <= 8'hff;
    cyc(5);
    chk({26'h0, feed}, 32'h0000_003f);
    chk({31'h0, pin_oe[2]}, 32'h0000_0000);
    // Pins 0, 2 and 5 high only, so a feed taken from the wrong pin shows
    board <= 8'h25;
    cyc(5);
    chk({26'h0, feed}, 32'h0000_002e);
    ctl <= '0;
    cyc(5);
    chk({26'h0, feed}, 32'h0000_0000);
  endtask

  initial begin
    {hresetn, hsel, hwrite, standby, board, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    ctl = '0;
    drv = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_mux();
    t_feed();
    complete_run();
  end

  // Cuts a hang short; the run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
